// ### include/cache_window_pkg.sv
// Purpose: shared constants and types of the prefetch cache data/lru window
// Assumes: classic wishbone slave, 32-bit data, byte addresses
// Notes:   offsets are byte addresses of aligned words

package cache_window_pkg;

	// ----------------------------------------------------------------
	// bus and array geometry
	// ----------------------------------------------------------------
	localparam int unsigned ADR_W   = 8;
	localparam int unsigned DAT_W   = 32;
	localparam int unsigned SEL_W   = 4;
	localparam int unsigned BYTE_W  = 8;
	localparam int unsigned IDX_W   = 4;
	localparam int unsigned LINES   = 16;
	localparam int unsigned LRU_W   = 25;
	localparam int unsigned WIN_CNT = 3;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [ADR_W-1:0] OFS_ACCESS_CONTROL = 8'h00;
	localparam logic [ADR_W-1:0] OFS_WORD_ONE       = 8'h04;
	localparam logic [ADR_W-1:0] OFS_WORD_TWO       = 8'h08;
	localparam logic [ADR_W-1:0] OFS_WORD_THREE     = 8'h0c;
	localparam logic [ADR_W-1:0] OFS_REPLACEMENT    = 8'h10;

	// ----------------------------------------------------------------
	// reset values and field masks
	// ----------------------------------------------------------------
	localparam logic [IDX_W-1:0] INDEX_RST  = 4'h0;
	localparam logic [LRU_W-1:0] LRU_RST    = 25'h0000000;
	localparam logic [DAT_W-1:0] READ_ZERO  = 32'h00000000;
	localparam logic [SEL_W-1:0] SEL_NONE   = 4'h0;

	// ----------------------------------------------------------------
	// bus slave states, one-hot
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		ST_IDLE  = 2'b01,
		ST_FETCH = 2'b10
	} slave_state_t;

endpackage

// ### rtl/cache_word_mem.sv
// Purpose: one data word of every cache line, byte-writable
// Assumes: single clock, write and read on the same edge
// Notes:   contents are not reset; read data come from a register

`timescale 1ns/1ps
`default_nettype none

module cache_word_mem (
	input  wire logic                                         ref_clk_i,
	input  wire logic                                         wr_en_i,
	input  wire logic [cache_window_pkg::SEL_W-1:0]           wr_sel_i,
	input  wire logic [cache_window_pkg::IDX_W-1:0]           addr_i,
	input  wire logic [cache_window_pkg::DAT_W-1:0]           wr_dat_i,
	output logic      [cache_window_pkg::DAT_W-1:0]           rd_dat_o
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [cache_window_pkg::LINES-1:0][cache_window_pkg::DAT_W-1:0] mem;
		logic [cache_window_pkg::DAT_W-1:0]                              rd;
	} mem_state_t;

	mem_state_t mem_r;
	mem_state_t mem_nxt;

	always_comb begin
		mem_nxt        = mem_r;
		// read sees the old word when written on the same edge
		mem_nxt.rd     = mem_r.mem[addr_i];
		for (int b = 0; b < cache_window_pkg::SEL_W; b++) begin
			if (wr_en_i && wr_sel_i[b]) begin
				mem_nxt.mem[addr_i][b*cache_window_pkg::BYTE_W +: cache_window_pkg::BYTE_W] =
					wr_dat_i[b*cache_window_pkg::BYTE_W +: cache_window_pkg::BYTE_W];
			end
		end
	end

	always_ff @(posedge ref_clk_i) begin
		mem_r <= mem_nxt;
	end

	assign rd_dat_o = mem_r.rd;

endmodule

`default_nettype wire

// ### rtl/cache_window.sv
// Purpose: software window into cache data words 1 to 3 and the lru state
// Assumes: classic wishbone slave on ref_clk_i, synchronous active-low reset
// Notes:   every access is answered with ack two edges after it is taken
//
// Overview of operation
// - word one window reads and writes all 32 bits of word 1 of indexed line.
// - word two window reads and writes all 32 bits of word 2 of indexed line.
// - word three window reads and writes all 32 bits of word 3 of indexed line.
// - data windows read as zero while code protection is active.
// - replacement state shows 25-bit pseudo-lru field, read-only, zero after reset.
// - upper seven replacement state bits read zero; software writes zero there.
// - 4-bit line select index picks the line the three data windows access.

`timescale 1ns/1ps
`default_nettype none

module cache_window (
	input  wire logic                                       ref_clk_i,
	input  wire logic                                       nrst_i,
	input  wire logic                                       wb_cyc_i,
	input  wire logic                                       wb_stb_i,
	input  wire logic                                       wb_we_i,
	input  wire logic [cache_window_pkg::ADR_W-1:0]         wb_adr_i,
	input  wire logic [cache_window_pkg::SEL_W-1:0]         wb_sel_i,
	input  wire logic [cache_window_pkg::DAT_W-1:0]         wb_dat_i,
	output logic                                            wb_ack_o,
	output logic      [cache_window_pkg::DAT_W-1:0]         wb_dat_o,
	input  wire logic                                       code_protect_i,
	input  wire logic [cache_window_pkg::LRU_W-1:0]         lru_state_i,
	output logic      [cache_window_pkg::IDX_W-1:0]         line_select_index_o
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		cache_window_pkg::slave_state_t          state;
		logic                                    ack;
		logic [cache_window_pkg::DAT_W-1:0]      dat;
		logic [cache_window_pkg::ADR_W-1:0]      adr;
		logic [cache_window_pkg::IDX_W-1:0]      index;
		logic [cache_window_pkg::LRU_W-1:0]      lru;
		logic                                    prot_meta;
		logic                                    prot;
	} win_state_t;

	win_state_t win_r;
	win_state_t win_nxt;

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	logic                                   req;
	logic                                   take;
	logic                                   take_wr;
	logic [cache_window_pkg::WIN_CNT-1:0]   word_hit;
	logic [cache_window_pkg::WIN_CNT-1:0]   word_wr;
	logic [cache_window_pkg::DAT_W-1:0]     word_rd [cache_window_pkg::WIN_CNT];
	logic [cache_window_pkg::DAT_W-1:0]     word_vis [cache_window_pkg::WIN_CNT];
	logic [cache_window_pkg::DAT_W-1:0]     rd_sel;
	logic                                   ctl_hit;
	logic                                   idx_wr;

	// win_r.ack guards the edge on which the master still holds its request
	assign req     = wb_cyc_i && wb_stb_i && !win_r.ack;
	assign take    = req && (win_r.state == cache_window_pkg::ST_IDLE);
	assign take_wr = take && wb_we_i;

	assign word_hit[0] = (wb_adr_i == cache_window_pkg::OFS_WORD_ONE);
	assign word_hit[1] = (wb_adr_i == cache_window_pkg::OFS_WORD_TWO);
	assign word_hit[2] = (wb_adr_i == cache_window_pkg::OFS_WORD_THREE);

	// writes are not blocked by protection; only reads of the array are
	assign word_wr = take_wr ? word_hit : '0;

	assign ctl_hit = (wb_adr_i == cache_window_pkg::OFS_ACCESS_CONTROL);
	// the index moves only with its own byte lane
	assign idx_wr  = take_wr && ctl_hit && wb_sel_i[0];

	// ----------------------------------------------------------------
	// data array, one memory per window word
	// ----------------------------------------------------------------
	genvar w;
	generate
		for (w = 0; w < cache_window_pkg::WIN_CNT; w++) begin : g_word
			cache_word_mem u_word (
				.ref_clk_i (ref_clk_i),
				.wr_en_i   (word_wr[w]),
				.wr_sel_i  (wb_sel_i),
				.addr_i    (win_r.index),
				.wr_dat_i  (wb_dat_i),
				.rd_dat_o  (word_rd[w])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// protected view of the array
	// ----------------------------------------------------------------
	// one masking point, so no window can bypass protection
	genvar v;
	generate
		for (v = 0; v < cache_window_pkg::WIN_CNT; v++) begin : g_vis
			assign word_vis[v] = win_r.prot ? cache_window_pkg::READ_ZERO : word_rd[v];
		end
	endgenerate

	// ----------------------------------------------------------------
	// read select
	// ----------------------------------------------------------------
	// decoded from the held address one edge after take, once the
	// memory read registers reflect the current index
	always_comb begin
		rd_sel = cache_window_pkg::READ_ZERO;
		case (win_r.adr)
			cache_window_pkg::OFS_ACCESS_CONTROL: begin
				rd_sel[cache_window_pkg::IDX_W-1:0] = win_r.index;
			end
			cache_window_pkg::OFS_WORD_ONE: begin
				rd_sel = word_vis[0];
			end
			cache_window_pkg::OFS_WORD_TWO: begin
				rd_sel = word_vis[1];
			end
			cache_window_pkg::OFS_WORD_THREE: begin
				rd_sel = word_vis[2];
			end
			cache_window_pkg::OFS_REPLACEMENT: begin
				// upper bits stay zero, writes are ignored
				rd_sel[cache_window_pkg::LRU_W-1:0] = win_r.lru;
			end
			default: begin
				rd_sel = cache_window_pkg::READ_ZERO;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		win_nxt           = win_r;
		// two flops before the protection level is used
		win_nxt.prot_meta = code_protect_i;
		win_nxt.prot      = win_r.prot_meta;
		win_nxt.lru       = lru_state_i;
		win_nxt.ack       = 1'b0;

		case (win_r.state)
			cache_window_pkg::ST_IDLE: begin
				if (take) begin
					win_nxt.adr   = wb_adr_i;
					win_nxt.state = cache_window_pkg::ST_FETCH;
					if (idx_wr) begin
						win_nxt.index = wb_dat_i[cache_window_pkg::IDX_W-1:0];
					end
				end
			end
			cache_window_pkg::ST_FETCH: begin
				// memory read data reflect the index and array as they stood before the take edge
				win_nxt.ack   = 1'b1;
				win_nxt.state = cache_window_pkg::ST_IDLE;
				win_nxt.dat   = rd_sel;
			end
			default: begin
				win_nxt.state = cache_window_pkg::ST_IDLE;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			win_r.state     <= cache_window_pkg::ST_IDLE;
			win_r.ack       <= 1'b0;
			win_r.dat       <= cache_window_pkg::READ_ZERO;
			win_r.adr       <= cache_window_pkg::OFS_ACCESS_CONTROL;
			win_r.index     <= cache_window_pkg::INDEX_RST;
			win_r.lru       <= cache_window_pkg::LRU_RST;
			// protected until proven otherwise, so no early leak
			win_r.prot_meta <= 1'b1;
			win_r.prot      <= 1'b1;
		end else begin
			win_r <= win_nxt;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign wb_ack_o            = win_r.ack;
	assign wb_dat_o            = win_r.dat;
	assign line_select_index_o = win_r.index;

endmodule

`default_nettype wire

// ### test/cache_window_asserts.sv
// Purpose: port checks on cache_window
// Assumes: one clock, synchronous active-low reset
// Notes:   bench holds lru_state_i steady around replacement reads
`timescale 1ns/1ps
`default_nettype none
module cache_window_asserts (
	input wire logic                                 ref_clk_i,
	input wire logic                                 nrst_i,
	input wire logic                                 wb_cyc_i,
	input wire logic                                 wb_stb_i,
	input wire logic                                 wb_we_i,
	input wire logic [cache_window_pkg::ADR_W-1:0]   wb_adr_i,
	input wire logic [cache_window_pkg::SEL_W-1:0]   wb_sel_i,
	input wire logic [cache_window_pkg::DAT_W-1:0]   wb_dat_i,
	input wire logic                                 wb_ack_o,
	input wire logic [cache_window_pkg::DAT_W-1:0]   wb_dat_o,
	input wire logic                                 code_protect_i,
	input wire logic [cache_window_pkg::LRU_W-1:0]   lru_state_i,
	input wire logic [cache_window_pkg::IDX_W-1:0]   line_select_index_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!nrst_i);
	wire logic rd_win = wb_ack_o && !wb_we_i && wb_adr_i inside {8'h04, 8'h08, 8'h0c};
	wire logic rd_rep = wb_ack_o && !wb_we_i && wb_adr_i == cache_window_pkg::OFS_REPLACEMENT;
	// ------------------------------------------------------------
	// bus handshake and data
	// ------------------------------------------------------------
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack wider than one cycle");
	ack_delay_a: assert property ($rose(wb_stb_i) && wb_cyc_i |-> ##2 wb_ack_o)
		else $error("ack not two edges after take");
	no_cyc_a: assert property (!wb_cyc_i |=> !wb_ack_o)
		else $error("ack without a cycle");
	dat_hold_a: assert property (!wb_ack_o |=> wb_ack_o || $stable(wb_dat_o))
		else $error("read data moved between answers");
	prot_zero_a: assert property (code_protect_i [*4] ##0 rd_win |-> wb_dat_o == 32'h0)
		else $error("window readable while protected");
	lru_upper_a: assert property (rd_rep |-> wb_dat_o[31:25] == 7'h0)
		else $error("replacement upper bits not zero");
	lru_value_a: assert property ($stable(lru_state_i) [*4] ##0 rd_rep |-> wb_dat_o[24:0] == lru_state_i)
		else $error("replacement state mismatch");
	idx_write_a: assert property ($rose(wb_stb_i) && wb_we_i && wb_adr_i == 8'h00
		&& wb_sel_i[0] |=> line_select_index_o == wb_dat_i[3:0])
		else $error("index not written");
	idx_hold_a: assert property (!(wb_cyc_i && wb_stb_i && wb_we_i) |=> $stable(line_select_index_o))
		else $error("index moved without a write");
	cover property (wb_ack_o && wb_we_i);
	cover property (code_protect_i [*4] ##0 rd_win);
	cover property (rd_rep && wb_dat_o != 32'h0);
endmodule
bind cache_window cache_window_asserts chk_u (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
	.code_protect_i(code_protect_i), .lru_state_i(lru_state_i),
	.line_select_index_o(line_select_index_o));
`default_nettype wire

// ### test/testbench.sv
// Purpose: self-checking bench for cache_window
// Assumes: ack comes two edges after a request is taken
// Notes:   model keeps words 1 to 3 of each written line
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin mismatches++; \
	$display("Error %0t: got %h expected %h", $time, g, e); end end
module testbench;
	logic        ref_clk_i = 1'h0;
	logic        nrst_i = 1'h0;
	logic        cyc = 1'h0;
	logic        stb = 1'h0;
	logic        we = 1'h0;
	logic        prot = 1'h0;
	logic        ack;
	logic [7:0]  adr = 8'h0;
	logic [3:0]  sel = 4'hf;
	logic [3:0]  idx;
	logic [31:0] dwr = 32'h0;
	logic [31:0] drd;
	logic [31:0] rd;
	logic [31:0] seed = 32'h47;
	logic [24:0] lru = 25'h0;
	logic [31:0] mem [16][3];
	int          mismatches = 0;
	int          check_count = 0;
	int          cycles = 0;
	always #50 ref_clk_i = ~ref_clk_i;
	cache_window dut_u (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dwr), .wb_ack_o(ack),
		.wb_dat_o(drd), .code_protect_i(prot), .lru_state_i(lru), .line_select_index_o(idx));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// a hang ends in the same report
	always @(posedge ref_clk_i) begin
		cycles++;
		if (cycles == 3000) begin
			mismatches++;
			end_of_test();
		end
	end
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s = 4'hf);
		@(posedge ref_clk_i);
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		sel <= s;
		adr <= a;
		dwr <= d;
		do @(posedge ref_clk_i); while (ack !== 1'h1);
		rd = drd;
		cyc <= 1'h0;
		stb <= 1'h0;
	endtask
	initial begin
		repeat (4) @(posedge ref_clk_i);
		nrst_i <= 1'h1;
		bus(1'h0, 8'h10, 32'h0);
		`CHK(rd, 32'h0)
		bus(1'h1, 8'h10, 32'hffffffff);
		bus(1'h0, 8'h10, 32'h0);
		`CHK(rd, 32'h0)
		bus(1'h0, 8'h14, 32'h0);
		`CHK(rd, 32'h0)
		$display("replacement after reset done");
		for (int l = 0; l < 16; l += 5) begin
			bus(1'h1, 8'h00, 32'(l));
			for (int k = 1; k < 4; k++) begin
				seed = lfsr(seed);
				mem[l][k-1] = seed;
				bus(1'h1, 8'(4 * k), seed);
				bus(1'h0, 8'(4 * k), 32'h0);
				`CHK(rd, mem[l][k-1])
			end
		end
		for (int l = 0; l < 16; l += 5) begin
			bus(1'h1, 8'h00, 32'(l));
			bus(1'h0, 8'h00, 32'h0);
			`CHK(idx, 4'(l))
			`CHK(rd, 32'(l))
			for (int k = 1; k < 4; k++) begin
				bus(1'h0, 8'(4 * k), 32'h0);
				`CHK(rd, mem[l][k-1])
			end
		end
		seed = lfsr(seed);
		mem[15][0] = {mem[15][0][31:16], seed[15:0]};
		bus(1'h1, 8'h04, seed, 4'h3);
		bus(1'h0, 8'h04, 32'h0);
		`CHK(rd, mem[15][0])
		bus(1'h1, 8'h00, 32'h00000003, 4'he);
		bus(1'h0, 8'h00, 32'h0);
		`CHK(rd, 32'h0000000f)
		`CHK(idx, 4'hf)
		$display("window read back done");
		prot <= 1'h1;
		for (int k = 1; k < 4; k++) begin
			bus(1'h0, 8'(4 * k), 32'h0);
			`CHK(rd, 32'h0)
		end
		seed = lfsr(seed);
		mem[15][2] = seed;
		bus(1'h1, 8'h0c, seed);
		prot <= 1'h0;
		repeat (3) @(posedge ref_clk_i);
		bus(1'h0, 8'h04, 32'h0);
		`CHK(rd, mem[15][0])
		bus(1'h0, 8'h0c, 32'h0);
		`CHK(rd, mem[15][2])
		$display("protection done");
		seed = lfsr(seed);
		lru <= seed[24:0];
		repeat (3) @(posedge ref_clk_i);
		bus(1'h0, 8'h10, 32'h0);
		`CHK(rd, {7'h0, seed[24:0]})
		$display("replacement state done");
		end_of_test();
	end
endmodule
`default_nettype wire
